// ==== design/mcsr_regs.sv ====
/*
 * Configuration and status register bank of a six-current-channel,
 * one-voltage-channel metering core. A serial engine outside this
 * module turns host frames into single-cycle register reads and writes
 * on the parallel access port below; the metering datapath supplies
 * no-load and power-sign levels on the same clock.
 */
// Behaviour
// RQ1: no_load_status bits 0..5 show the idle flag of channels A..F, 1 while idle.
// RQ2: group select bit 14 picks channels A,B,C when 0 and D,E,F when 1 for measurements.
// RQ3: phase bits 10:9: 00 voltage-to-current delay, 10 current angles, 11 none, 01 reserved.
// RQ4: host keeps the low nine computation_mode bits, reset to all ones, unchanged on writes.
// RQ5: gain bits 8:6 set the gain of current channels D, E and F.
// RQ6: gain bits 5:3 set the gain of the voltage channel.
// RQ7: gain bits 2:0 set the gain of current channels A, B and C.
// RQ8: gain codes 000..100 mean 1, 2, 4, 8, 16 and codes 101..111 are reserved.
// RQ9: sign bits 0..2 show the active power sign of the first..third channel of the group.
// RQ10: sign bits 4..6 show the reactive power sign of the first..third channel of the group.
// RQ11: writing 1 to config bit 7 starts a software reset.
// RQ12: config bit 6 enables the waveform capture port.
// RQ13: config bit 0 inserts the digital integrator in the current paths.
// RQ14: host sets the sign group selects to match the measurement group select.
// RQ15: the soft reset bit clears itself when done and configuration returns to defaults.
`timescale 1ns/1ps
`default_nettype none

module mcsr_regs #(
    parameter int RESET_CYCLES = mcsr_pkg::SOFT_RESET_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    // register access port
    input wire logic [15:0] reg_addr,
    input wire logic reg_write,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // datapath status
    input wire logic [5:0] idle_flag,
    input wire logic [5:0] active_neg,
    input wire logic [5:0] reactive_neg,
    input wire logic active_sign_group,
    input wire logic reactive_sign_group,
    // configuration outputs
    output logic group_select,
    output logic [5:0] measure_channel_mask,
    output mcsr_pkg::mcsr_phase_e phase_measure_select,
    output logic measure_v_to_i,
    output logic measure_i_to_i,
    output logic [2:0] gain_code_group1,
    output logic [2:0] gain_code_voltage,
    output logic [2:0] gain_code_group2,
    output logic [4:0] gain_factor_group1,
    output logic [4:0] gain_factor_voltage,
    output logic [4:0] gain_factor_group2,
    output logic gain_code_invalid,
    output logic capture_port_enable,
    output logic integrator_enable,
    output logic soft_reset_active
);
    import mcsr_pkg::*;

    localparam int CNT_W = (RESET_CYCLES > 1) ? $clog2(RESET_CYCLES + 1) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RESET_CYCLES - 1);

    // ========================================================
    // write decode
    logic wr_cmp;
    logic wr_gain;
    logic wr_cfg;
    logic soft_reset_reg;
    logic soft_reset_done;
    logic soft_reset_start;

    // writes are dropped while a soft reset runs so defaults come back clean
    assign wr_cmp = reg_write && !soft_reset_reg && (reg_addr == ADDR_COMPUTATION_MODE);
    assign wr_gain = reg_write && !soft_reset_reg && (reg_addr == ADDR_CHANNEL_GAIN);
    assign wr_cfg = reg_write && !soft_reset_reg && (reg_addr == ADDR_DEVICE_CONFIG);
    assign soft_reset_start = wr_cfg && reg_wdata[CFG_SOFT_RESET_BIT]; // [RQ11]

    // ========================================================
    // software reset sequencer
    logic [CNT_W-1:0] rst_cnt_reg;

    assign soft_reset_done = soft_reset_reg && (rst_cnt_reg == CNT_LAST);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            soft_reset_reg <= 1'b0;
        end else if (soft_reset_start) begin
            soft_reset_reg <= 1'b1; // [RQ11]
        end else if (soft_reset_done) begin
            soft_reset_reg <= 1'b0; // [RQ15]
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rst_cnt_reg <= '0;
        end else if (soft_reset_reg && !soft_reset_done) begin
            rst_cnt_reg <= rst_cnt_reg + CNT_W'(1);
        end else begin
            rst_cnt_reg <= '0;
        end
    end

    assign soft_reset_active = soft_reset_reg;

    // ========================================================
    // computation_mode
    logic group_sel_reg;
    mcsr_phase_e phase_sel_reg;
    logic [8:0] cmp_rsvd_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            group_sel_reg <= CMP_GROUP_SEL_RESET;
            phase_sel_reg <= CMP_PHASE_RESET;
            cmp_rsvd_reg <= CMP_RSVD_RESET;
        end else if (soft_reset_done) begin
            group_sel_reg <= CMP_GROUP_SEL_RESET; // [RQ15]
            phase_sel_reg <= CMP_PHASE_RESET;
            cmp_rsvd_reg <= CMP_RSVD_RESET;
        end else if (wr_cmp) begin
            group_sel_reg <= reg_wdata[CMP_GROUP_SEL_BIT];
            phase_sel_reg <= mcsr_phase_e'(reg_wdata[CMP_PHASE_SEL_MSB:CMP_PHASE_SEL_LSB]);
            // stored as written; keeping them at ones is the host's job [RQ4]
            cmp_rsvd_reg <= reg_wdata[CMP_RSVD_MSB:0];
        end
    end

    assign group_select = group_sel_reg;
    assign measure_channel_mask = group_sel_reg ? 6'h38 : 6'h07; // [RQ2]
    assign phase_measure_select = phase_sel_reg;

    always_comb begin
        measure_v_to_i = 1'b0;
        measure_i_to_i = 1'b0;
        case (phase_sel_reg)
            MCSR_PHASE_V_TO_I: measure_v_to_i = 1'b1; // [RQ3]
            MCSR_PHASE_I_TO_I: measure_i_to_i = 1'b1; // [RQ3]
            // reserved code measures nothing, like the none code
            MCSR_PHASE_NONE: begin
                measure_v_to_i = 1'b0;
            end
            default: begin
                measure_v_to_i = 1'b0;
            end
        endcase
    end

    // ========================================================
    // channel_gain
    logic [2:0] gain_code_reg [3];
    logic [2:0] gain_invalid;
    logic [4:0] gain_factor [3];
    localparam int GAIN_LSB [3] = '{GAIN_GROUP1_LSB, GAIN_VOLTAGE_LSB, GAIN_GROUP2_LSB};

    for (genvar g = 0; g < 3; g++) begin : gen_gain
        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                gain_code_reg[g] <= GAIN_CODE_RESET;
            end else if (soft_reset_done) begin
                gain_code_reg[g] <= GAIN_CODE_RESET; // [RQ15]
            end else if (wr_gain) begin
                gain_code_reg[g] <= reg_wdata[GAIN_LSB[g] +: GAIN_CODE_W]; // [RQ5] [RQ6] [RQ7]
            end
        end
        // reserved codes fall back to unity gain rather than an unknown stage
        assign gain_invalid[g] = gain_code_reg[g] > GAIN_CODE_MAX; // [RQ8]
        assign gain_factor[g] = gain_invalid[g] ? 5'h01 : (5'h01 << gain_code_reg[g]); // [RQ8]
    end

    assign gain_code_group1 = gain_code_reg[0];
    assign gain_code_voltage = gain_code_reg[1];
    assign gain_code_group2 = gain_code_reg[2];
    assign gain_factor_group1 = gain_factor[0]; // [RQ7]
    assign gain_factor_voltage = gain_factor[1]; // [RQ6]
    assign gain_factor_group2 = gain_factor[2]; // [RQ5]
    assign gain_code_invalid = |gain_invalid;

    // ========================================================
    // device_config
    logic capture_en_reg;
    logic integrator_en_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            capture_en_reg <= CFG_BIT_RESET;
            integrator_en_reg <= CFG_BIT_RESET;
        end else if (soft_reset_done) begin
            capture_en_reg <= CFG_BIT_RESET; // [RQ15]
            integrator_en_reg <= CFG_BIT_RESET;
        end else if (wr_cfg) begin
            capture_en_reg <= reg_wdata[CFG_CAPTURE_EN_BIT]; // [RQ12]
            integrator_en_reg <= reg_wdata[CFG_INTEGRATOR_BIT]; // [RQ13]
        end
    end

    assign capture_port_enable = capture_en_reg; // [RQ12]
    assign integrator_enable = integrator_en_reg; // [RQ13]

    // ========================================================
    // sign selection; group selects come from the accumulation mode settings
    logic [2:0] active_sel;
    logic [2:0] reactive_sel;

    // relies on the host matching both selects to group_select [RQ14]
    assign active_sel = active_sign_group ? active_neg[5:3] : active_neg[2:0]; // [RQ9]
    assign reactive_sel = reactive_sign_group ? reactive_neg[5:3] : reactive_neg[2:0]; // [RQ10]

    // ========================================================
    // read path
    logic [15:0] rd_mux;

    always_comb begin
        rd_mux = 16'h0000;
        case (reg_addr)
            ADDR_NO_LOAD_STATUS: rd_mux[5:0] = idle_flag; // [RQ1]
            ADDR_COMPUTATION_MODE: begin
                rd_mux[CMP_GROUP_SEL_BIT] = group_sel_reg;
                rd_mux[CMP_PHASE_SEL_MSB:CMP_PHASE_SEL_LSB] = phase_sel_reg;
                rd_mux[CMP_RSVD_MSB:0] = cmp_rsvd_reg;
            end
            ADDR_CHANNEL_GAIN: begin
                rd_mux[GAIN_GROUP2_LSB +: GAIN_CODE_W] = gain_code_reg[2];
                rd_mux[GAIN_VOLTAGE_LSB +: GAIN_CODE_W] = gain_code_reg[1];
                rd_mux[GAIN_GROUP1_LSB +: GAIN_CODE_W] = gain_code_reg[0];
            end
            ADDR_POWER_SIGN_STATUS: begin
                rd_mux[SIGN_ACTIVE_LSB +: 3] = active_sel; // [RQ9]
                rd_mux[SIGN_REACTIVE_LSB +: 3] = reactive_sel; // [RQ10]
            end
            ADDR_DEVICE_CONFIG: begin
                rd_mux[CFG_SOFT_RESET_BIT] = soft_reset_reg;
                rd_mux[CFG_CAPTURE_EN_BIT] = capture_en_reg;
                rd_mux[CFG_INTEGRATOR_BIT] = integrator_en_reg;
            end
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read;
            if (reg_read) begin
                reg_rdata <= rd_mux;
            end
        end
    end

endmodule : mcsr_regs

`default_nettype wire

// ==== include/mcsr_pkg.sv ====
/*
 * Constants for the metering configuration and status register bank:
 * register addresses, field positions, reset values, gain codes and
 * software-reset timing. Assumes a 250 MHz system clock.
 */
package mcsr_pkg;

    // ========================================================
    // register addresses
    localparam logic [15:0] ADDR_NO_LOAD_STATUS = 16'he608;
    localparam logic [15:0] ADDR_COMPUTATION_MODE = 16'he60e;
    localparam logic [15:0] ADDR_CHANNEL_GAIN = 16'he60f;
    localparam logic [15:0] ADDR_POWER_SIGN_STATUS = 16'he617;
    localparam logic [15:0] ADDR_DEVICE_CONFIG = 16'he618;

    // ========================================================
    // computation_mode fields
    localparam int CMP_GROUP_SEL_BIT = 14;
    localparam int CMP_PHASE_SEL_LSB = 9;
    localparam int CMP_PHASE_SEL_MSB = 10;
    localparam int CMP_RSVD_MSB = 8;
    localparam logic [8:0] CMP_RSVD_RESET = 9'h1ff;
    localparam logic CMP_GROUP_SEL_RESET = 1'b0;

    typedef enum logic [1:0] {
        MCSR_PHASE_V_TO_I = 2'b00,
        MCSR_PHASE_RSVD = 2'b01,
        MCSR_PHASE_I_TO_I = 2'b10,
        MCSR_PHASE_NONE = 2'b11
    } mcsr_phase_e;
    localparam mcsr_phase_e CMP_PHASE_RESET = MCSR_PHASE_V_TO_I;

    // ========================================================
    // channel_gain fields
    localparam int GAIN_GROUP2_LSB = 6;
    localparam int GAIN_VOLTAGE_LSB = 3;
    localparam int GAIN_GROUP1_LSB = 0;
    localparam int GAIN_CODE_W = 3;
    localparam logic [2:0] GAIN_CODE_RESET = 3'h0;
    localparam logic [2:0] GAIN_CODE_MAX = 3'h4;

    // ========================================================
    // power_sign_status fields
    localparam int SIGN_ACTIVE_LSB = 0;
    localparam int SIGN_REACTIVE_LSB = 4;

    // ========================================================
    // device_config fields
    localparam int CFG_SOFT_RESET_BIT = 7;
    localparam int CFG_CAPTURE_EN_BIT = 6;
    localparam int CFG_INTEGRATOR_BIT = 0;
    localparam logic CFG_BIT_RESET = 1'b0;

    // ========================================================
    // software reset timing
    localparam int SOFT_RESET_TIME_NS = 64;
    localparam int CLOCK_PERIOD_NS = 4;
    localparam int SOFT_RESET_CYCLES =
        (SOFT_RESET_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

endpackage : mcsr_pkg

// ==== sim/mcsr_host_model.sv ====
/* host model: register reads and writes on the parallel access port.
   assumes: one clock; the bench calls wr and rd once reset is released. */
`timescale 1ns/1ps
`default_nettype none
module mcsr_host_model (
    input wire logic clock,
    output logic [15:0] reg_addr,
    output logic reg_write,
    output logic [15:0] reg_wdata,
    output logic reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic active_sign_group,
    output logic reactive_sign_group
);
    import mcsr_pkg::*;
    initial begin
        {reg_addr, reg_write, reg_wdata, reg_read} = '0;
        {active_sign_group, reactive_sign_group} = 2'h0;
    end
    // released lines are inverted so stale values never look valid
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (a == ADDR_COMPUTATION_MODE) v[CMP_RSVD_MSB:0] = CMP_RSVD_RESET;
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
        if (a == ADDR_COMPUTATION_MODE) begin
            active_sign_group <= v[CMP_GROUP_SEL_BIT];
            reactive_sign_group <= v[CMP_GROUP_SEL_BIT];
        end
        @(negedge clock);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        @(negedge clock);
        d = reg_rdata;
        ok = reg_rvalid;
    endtask : rd
endmodule : mcsr_host_model
`default_nettype wire

// ==== sim/mcsr_regs_checker.sv ====
/* checker: port relations of the metering register bank.
   assumes: bound to mcsr_regs, one clock, sys_rst async active high. */
`timescale 1ns/1ps
`default_nettype none
module mcsr_regs_checker #(
    parameter int RESET_CYCLES = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_write,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_read,
    input wire logic reg_rvalid,
    input wire logic group_select,
    input wire logic [5:0] measure_channel_mask,
    input wire mcsr_pkg::mcsr_phase_e phase_measure_select,
    input wire logic measure_v_to_i,
    input wire logic measure_i_to_i,
    input wire logic [2:0] gain_code_group1,
    input wire logic [2:0] gain_code_voltage,
    input wire logic [2:0] gain_code_group2,
    input wire logic [4:0] gain_factor_group1,
    input wire logic capture_port_enable,
    input wire logic integrator_enable,
    input wire logic soft_reset_active
);
    import mcsr_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic [7:0] srst_cnt;
    logic cfg_wr;
    logic gain_wr;
    // writes during a soft reset are dropped, so they never count
    assign cfg_wr = reg_write && reg_addr == ADDR_DEVICE_CONFIG && !soft_reset_active;
    assign gain_wr = reg_write && reg_addr == ADDR_CHANNEL_GAIN && !soft_reset_active;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            srst_cnt <= 8'h0;
        end else begin
            srst_cnt <= soft_reset_active ? srst_cnt + 8'h1 : 8'h0;
        end
    end
    property p_mask;
        measure_channel_mask == (group_select ? 6'h38 : 6'h07);
    endproperty
    a_mask: assert property (p_mask) else $error("channel mask disagrees with group");
    property p_phase;
        measure_v_to_i == (phase_measure_select == MCSR_PHASE_V_TO_I) &&
            measure_i_to_i == (phase_measure_select == MCSR_PHASE_I_TO_I);
    endproperty
    a_phase: assert property (p_phase) else $error("phase decode wrong");
    property p_rd_answer;
        reg_read |=> reg_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_cause;
        reg_rvalid |-> $past(reg_read);
    endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("read valid without read");
    property p_cfg;
        cfg_wr && !reg_wdata[CFG_SOFT_RESET_BIT] |=>
            capture_port_enable == $past(reg_wdata[CFG_CAPTURE_EN_BIT]) &&
            integrator_enable == $past(reg_wdata[CFG_INTEGRATOR_BIT]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config enables not taken");
    property p_gain;
        gain_wr |=> {gain_code_group2, gain_code_voltage, gain_code_group1} ==
            $past(reg_wdata[8:0]);
    endproperty
    a_gain: assert property (p_gain) else $error("gain codes not taken");
    property p_factor;
        gain_factor_group1 ==
            (gain_code_group1 <= GAIN_CODE_MAX ? 5'h1 << gain_code_group1 : 5'h1);
    endproperty
    a_factor: assert property (p_factor) else $error("gain factor wrong");
    property p_srst_go;
        cfg_wr && reg_wdata[CFG_SOFT_RESET_BIT] |=> soft_reset_active;
    endproperty
    a_srst_go: assert property (p_srst_go) else $error("soft reset not started");
    property p_srst_end;
        $fell(soft_reset_active) |-> srst_cnt == RESET_CYCLES && !capture_port_enable &&
            !integrator_enable && !group_select;
    endproperty
    a_srst_end: assert property (p_srst_end) else $error("soft reset length or defaults");
    c_srst: cover property ($fell(soft_reset_active));
    c_group: cover property (group_select && measure_i_to_i);
    c_read: cover property (reg_rvalid);
endmodule : mcsr_regs_checker
bind mcsr_regs mcsr_regs_checker #(.RESET_CYCLES(RESET_CYCLES)) mcsr_regs_checker_inst (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rvalid(reg_rvalid),
    .group_select(group_select), .measure_channel_mask(measure_channel_mask),
    .phase_measure_select(phase_measure_select), .measure_v_to_i(measure_v_to_i),
    .measure_i_to_i(measure_i_to_i), .gain_code_group1(gain_code_group1),
    .gain_code_voltage(gain_code_voltage), .gain_code_group2(gain_code_group2),
    .gain_factor_group1(gain_factor_group1), .capture_port_enable(capture_port_enable),
    .integrator_enable(integrator_enable), .soft_reset_active(soft_reset_active)
);
`default_nettype wire

// ==== sim/tb_metering_config_status_regs.sv ====
/* bench: drives the register bank through the host model and checks
   outputs and read-back. assumes: 250 MHz clock, short soft reset. */
`timescale 1ns/1ps
`default_nettype none
module tb_metering_config_status_regs;
    import mcsr_pkg::*;
    localparam int RST_CYC = 3;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, rdv;
    logic reg_write, reg_read, reg_rvalid, active_sign_group, reactive_sign_group, rok, gs;
    logic [5:0] idle_flag = 6'h2a;
    logic [5:0] active_neg = 6'b101100;
    logic [5:0] reactive_neg = 6'b010011;
    logic group_select, measure_v_to_i, measure_i_to_i, gain_code_invalid;
    logic capture_port_enable, integrator_enable, soft_reset_active;
    logic [5:0] measure_channel_mask;
    mcsr_phase_e phase_measure_select, ph;
    logic [2:0] gain_code_group1, gain_code_voltage, gain_code_group2, k1, kv, k2;
    logic [4:0] gain_factor_group1, gain_factor_voltage, gain_factor_group2;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    int n;
    mcsr_regs #(.RESET_CYCLES(RST_CYC)) mcsr_regs_inst (
        .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .idle_flag(idle_flag), .active_neg(active_neg),
        .reactive_neg(reactive_neg), .active_sign_group(active_sign_group),
        .reactive_sign_group(reactive_sign_group), .group_select(group_select),
        .measure_channel_mask(measure_channel_mask),
        .phase_measure_select(phase_measure_select), .measure_v_to_i(measure_v_to_i),
        .measure_i_to_i(measure_i_to_i), .gain_code_group1(gain_code_group1),
        .gain_code_voltage(gain_code_voltage), .gain_code_group2(gain_code_group2),
        .gain_factor_group1(gain_factor_group1), .gain_factor_voltage(gain_factor_voltage),
        .gain_factor_group2(gain_factor_group2), .gain_code_invalid(gain_code_invalid),
        .capture_port_enable(capture_port_enable), .integrator_enable(integrator_enable),
        .soft_reset_active(soft_reset_active)
    );
    mcsr_host_model host (
        .clock(clock), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .active_sign_group(active_sign_group), .reactive_sign_group(reactive_sign_group)
    );
    always #2 clock = ~clock;
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
        host.rd(a, rdv, rok);
        chk("rvalid", {15'h0, rok}, 16'h1);
        chk("rdata", rdv, exp);
    endtask : rchk
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    // the run needs well under a thousand cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            complete_run();
        end
    end
    // ==================================================
    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        rchk(ADDR_COMPUTATION_MODE, 16'h01ff);
        rchk(ADDR_CHANNEL_GAIN, 16'h0000);
        rchk(16'he610, 16'h0000);
        rchk(ADDR_NO_LOAD_STATUS, 16'h002a);
        host.wr(ADDR_NO_LOAD_STATUS, 16'hffff);
        @(posedge clock);
        idle_flag <= 6'h15;
        rchk(ADDR_NO_LOAD_STATUS, 16'h0015);
        $display("test reset and status done");
        for (int c = 0; c < 5; c++) begin
            k2 = 3'(c);
            kv = 3'((c + 1) % 5);
            k1 = 3'((c + 2) % 5);
            host.wr(ADDR_CHANNEL_GAIN, {7'h0, k2, kv, k1});
            chk("gain d-f", {11'h0, gain_factor_group2}, 16'h1 << k2);
            chk("gain v", {11'h0, gain_factor_voltage}, 16'h1 << kv);
            chk("gain a-c", {11'h0, gain_factor_group1}, 16'h1 << k1);
            chk("codes", {7'h0, gain_code_group2, gain_code_voltage, gain_code_group1},
                {7'h0, k2, kv, k1});
            chk("gain bad", {15'h0, gain_code_invalid}, 16'h0);
            rchk(ADDR_CHANNEL_GAIN, {7'h0, k2, kv, k1});
        end
        $display("test gain done");
        for (int m = 0; m < 4; m++) begin
            ph = (m == 0) ? MCSR_PHASE_V_TO_I : (m == 1) ? MCSR_PHASE_I_TO_I :
                (m == 2) ? MCSR_PHASE_NONE : MCSR_PHASE_RSVD;
            gs = 1'(m % 2);
            host.wr(ADDR_COMPUTATION_MODE, {1'b0, gs, 3'h0, ph, 9'h0});
            chk("mask", {10'h0, measure_channel_mask}, gs ? 16'h0038 : 16'h0007);
            chk("phase code", {14'h0, phase_measure_select}, {14'h0, ph});
            chk("phase", {14'h0, measure_v_to_i, measure_i_to_i},
                {14'h0, ph == MCSR_PHASE_V_TO_I, ph == MCSR_PHASE_I_TO_I});
            rchk(ADDR_COMPUTATION_MODE, {1'b0, gs, 3'h0, ph, 9'h1ff});
            rchk(ADDR_POWER_SIGN_STATUS, {9'h0, gs ? reactive_neg[5:3] : reactive_neg[2:0],
                1'b0, gs ? active_neg[5:3] : active_neg[2:0]});
        end
        $display("test mode and sign done");
        host.wr(ADDR_DEVICE_CONFIG, 16'h0041);
        chk("enables", {14'h0, capture_port_enable, integrator_enable}, 16'h0003);
        rchk(ADDR_DEVICE_CONFIG, 16'h0041);
        host.wr(ADDR_COMPUTATION_MODE, 16'h4000);
        host.wr(ADDR_DEVICE_CONFIG, 16'h0080);
        chk("soft reset", {15'h0, soft_reset_active}, 16'h0001);
        host.wr(ADDR_DEVICE_CONFIG, 16'h0040);
        n = 0;
        while (soft_reset_active !== 1'b0 && n < 20) begin
            @(negedge clock);
            n++;
        end
        chk("defaults", {13'h0, group_select, capture_port_enable, integrator_enable},
            16'h0);
        rchk(ADDR_DEVICE_CONFIG, 16'h0000);
        rchk(ADDR_COMPUTATION_MODE, 16'h01ff);
        $display("test soft reset done");
        complete_run();
    end
endmodule : tb_metering_config_status_regs
`default_nettype wire
